// ---- acc_cfg.svh ----
/*
  Constants of the cell convergence block: cell layout, header check,
  scrambler, delineation defaults, maintenance message codes and register map.
  Assumes inclusion by bare name from the design module.
*/
`ifndef ACC_CFG_SVH
`define ACC_CFG_SVH
// Cell layout, byte index within a 53-byte cell
`define ACC_CELL_LAST 6'd52
`define ACC_HEC_IDX 6'd4
`define ACC_PAY_FIRST 6'd5
`define ACC_MSG_LEN 3'd4
// Header check and idle cell
`define ACC_CRC_POLY 8'h07
`define ACC_HEC_COSET 8'h55
`define ACC_IDLE_HDR 32'h0000_0001
`define ACC_IDLE_PAY 8'h6a
`define ACC_SCR_LEN 43
// Delineation and defect defaults
`define ACC_LOST_DEF 4'h7
`define ACC_CONF_DEF 4'h6
`define ACC_N_MIN 6'd3
`define ACC_N_MAX 6'd36
`define ACC_N_DEF 6'd3
`define ACC_PERSIST_DEF 8'h28
`define ACC_LCD_FRAMES 4'h9
// Maintenance message identifiers
`define ACC_MSG_REQ 8'h11
`define ACC_MSG_STAT 8'h91
// Report repetition time
`define ACC_REPORT_PERIOD_MS 1000
`define ACC_CLK_KHZ 200000
// Register byte addresses
`define ACC_A_CTRL 8'h00
`define ACC_A_STATUS 8'h04
`define ACC_A_HVC 8'h08
`define ACC_A_HTC 8'h0c
`define ACC_A_HVC_TOT 8'h10
`define ACC_A_HTC_TOT 8'h14
// Control register fields
`define ACC_F_LOST 3:0
`define ACC_F_CONF 7:4
`define ACC_F_NCH 13:8
`define ACC_F_ZCH 18:16
`define ACC_F_PERSIST 31:24
`endif

// ---- acc_pkg.sv ----
/*
  Types of the cell convergence block: delineation states, port carriers
  and the single state record of the design module.
  Assumes acc_cfg.svh sits in the include path.
*/
`default_nettype none
package acc_pkg;
  typedef enum logic [1:0] {
    ACC_HUNT = 2'b00,
    ACC_PRESYNC = 2'b01,
    ACC_SYNC = 2'b10
  } acc_dlin_t;
  typedef struct packed {
    logic [7:0] addr; logic [31:0] wdata; logic wr; logic rd;
  } acc_bus_t;
  typedef struct packed {logic [7:0] data; logic valid; logic sop;} acc_byte_t;
  typedef struct packed {logic [7:0] data; logic valid;} acc_lbyte_t;
  typedef struct packed {
    logic [31:0] hdr; logic hdr_valid; logic [7:0] data; logic valid;
  } acc_cell_out_t;
  typedef struct packed {
    logic [3:0] lost_thr; logic [3:0] conf_thr; logic [5:0] n_ch;
    logic [2:0] z_ch; logic [7:0] persist;
    logic [5:0] tx_idx; logic tx_user; logic [7:0] tx_crc;
    logic [42:0] tx_scr; acc_lbyte_t line_tx; logic tx_ack;
    acc_dlin_t dl; logic [5:0] rx_idx; logic [39:0] win;
    logic [42:0] rx_scr; logic [3:0] good_cnt; logic [3:0] bad_cnt;
    logic fwd; acc_cell_out_t rx_out;
    logic seen_data; logic ever_sync; logic nncd; logic nocd;
    logic ocd_frame; logic nlcd; logic [3:0] lcd_cnt;
    logic [1:0][7:0] pers; logic [1:0] fail; logic fail_q; logic acked;
    logic ocd_stk; logic lcd_stk;
    logic [15:0] hvc; logic [31:0] htc; logic [31:0] hvc_tot;
    logic [31:0] htc_tot;
    logic fncd; logic focd; logic fhec; logic flcd;
    logic [2:0] eoc_idx; logic [7:0] eoc_id; logic [7:0] eoc_b2;
    logic [7:0] eoc_hi;
    logic [27:0] timer; logic [31:0] msg; logic [2:0] msg_left; logic pend;
    acc_byte_t eoc_o; logic [31:0] rdata;
  } acc_st_t;
endpackage
`default_nettype wire

// ---- acc_convergence.sv ----
/*
  Cell transmission convergence with delineation, defect tracking and the
  cell status maintenance messages, all in one state record.
  Assumes every input comes from logic on clock_i (line framer, cell layer,
  maintenance channel, register master); no pin is sampled here directly.
*/
`timescale 1ns/1ps
`default_nettype none
`include "acc_cfg.svh"
module acc_convergence
  import acc_pkg::*;
#(
  parameter int unsigned REPORT_CYC = `ACC_REPORT_PERIOD_MS * `ACC_CLK_KHZ
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire acc_bus_t bus_i,
  output logic [31:0] bus_rdata_o,
  input wire acc_byte_t tx_cell_i,
  output logic tx_ack_o,
  input wire logic line_tx_req_i,
  output acc_lbyte_t line_tx_o,
  input wire acc_lbyte_t line_rx_i,
  output acc_cell_out_t rx_cell_o,
  input wire logic frame_i,
  input wire logic losw_i,
  input wire acc_byte_t eoc_rx_i,
  output acc_byte_t eoc_tx_o,
  input wire logic eoc_tx_ready_i
);
  localparam logic [31:0] IDLE_HDR = `ACC_IDLE_HDR;
  localparam logic [27:0] PERIOD_LAST = 28'(REPORT_CYC - 1);

  acc_st_t s_r;
  acc_st_t s_nxt;

  // Bitwise header CRC step, msb of the byte first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c;
    for (int k = 7; k >= 0; k--) begin
      r = {r[6:0], 1'b0} ^ (((r[7] ^ d[k]) != 1'b0) ? `ACC_CRC_POLY : 8'h00);
    end
    return r;
  endfunction

  // Header check byte with coset already applied
  function automatic logic [7:0] hec(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int k = 3; k >= 0; k--) begin
      c = crc8(c, h[8*k +: 8]);
    end
    return c ^ `ACC_HEC_COSET;
  endfunction

  // Self-synchronising x^43+1 on one byte; history holds line bits
  function automatic logic [50:0] scr8(input logic [42:0] h,
                                       input logic [7:0] d,
                                       input logic desc);
    logic [42:0] sh;
    logic [7:0] o;
    sh = h;
    o = 8'h00;
    for (int k = 7; k >= 0; k--) begin
      o[k] = d[k] ^ sh[`ACC_SCR_LEN-1];
      sh = {sh[41:0], desc ? d[k] : o[k]};
    end
    return {sh, o};
  endfunction

  // Outputs straight from the state record
  assign bus_rdata_o = s_r.rdata;
  assign tx_ack_o = s_r.tx_ack;
  assign line_tx_o = s_r.line_tx;
  assign rx_cell_o = s_r.rx_out;
  assign eoc_tx_o = s_r.eoc_o;

  logic cfg_ok;
  logic [39:0] win_nxt;
  logic match;
  logic is_idle;
  logic user;
  logic [7:0] tb;
  logic [7:0] pay;
  logic nhec;
  logic lost;
  logic reach_sync;
  logic htc_inc;
  logic req;
  logic hit;
  logic fail_any;
  logic auto_send;
  logic snap;
  logic [7:0] oct2;
  logic [1:0] cond;

  // Next-state logic for the whole block
  always_comb begin
    s_nxt = s_r;
    user = 1'b0;
    tb = 8'h00;
    pay = 8'h00;
    nhec = 1'b0;
    lost = 1'b0;
    reach_sync = 1'b0;
    htc_inc = 1'b0;
    req = 1'b0;
    hit = 1'b0;
    snap = 1'b0;
    s_nxt.tx_ack = 1'b0;
    s_nxt.line_tx.valid = 1'b0;
    s_nxt.rx_out.hdr_valid = 1'b0;
    s_nxt.rx_out.valid = 1'b0;
    s_nxt.rdata = 32'h0;
    cfg_ok = s_r.n_ch >= `ACC_N_MIN && s_r.n_ch <= `ACC_N_MAX
             && s_r.z_ch == 3'h0;
    win_nxt = {s_r.win[31:0], line_rx_i.data};
    match = hec(win_nxt[39:8]) == win_nxt[7:0];
    is_idle = win_nxt[39:8] == IDLE_HDR;

    // Transmit: one byte per line request, bit 7 leaves first
    if (line_tx_req_i) begin
      s_nxt.tx_idx = (s_r.tx_idx == `ACC_CELL_LAST) ? 6'h0
                     : s_r.tx_idx + 6'h1;
      user = s_r.tx_user;
      if (s_r.tx_idx == 6'h0) begin
        user = cfg_ok & tx_cell_i.valid & tx_cell_i.sop;
        s_nxt.tx_user = user;
      end
      if (s_r.tx_idx < `ACC_HEC_IDX) begin
        tb = user ? tx_cell_i.data
             : IDLE_HDR[8*(3 - s_r.tx_idx[1:0]) +: 8];
        s_nxt.tx_crc = crc8((s_r.tx_idx == 6'h0) ? 8'h00 : s_r.tx_crc, tb);
        s_nxt.tx_ack = user;
      end else if (s_r.tx_idx == `ACC_HEC_IDX) begin
        tb = s_r.tx_crc ^ `ACC_HEC_COSET;
      end else begin
        {s_nxt.tx_scr, tb} = scr8(s_r.tx_scr,
                                  user ? tx_cell_i.data : `ACC_IDLE_PAY,
                                  1'b0);
        s_nxt.tx_ack = user;
      end
      s_nxt.line_tx.data = tb;
      s_nxt.line_tx.valid = 1'b1;
    end

    // Receive delineation, one step per line byte
    if (line_rx_i.valid) begin
      s_nxt.seen_data = 1'b1;
      s_nxt.win = win_nxt;
      unique case (s_r.dl)
        ACC_HUNT: begin
          if (match) begin
            s_nxt.dl = ACC_PRESYNC;
            s_nxt.rx_idx = `ACC_PAY_FIRST;
            s_nxt.good_cnt = 4'h0;
            s_nxt.fwd = 1'b0;
          end
        end
        ACC_PRESYNC, ACC_SYNC: begin
          s_nxt.rx_idx = (s_r.rx_idx == `ACC_CELL_LAST) ? 6'h0
                         : s_r.rx_idx + 6'h1;
          if (s_r.rx_idx == `ACC_HEC_IDX) begin
            nhec = !match;
            s_nxt.fwd = 1'b0;
            if (s_r.dl == ACC_PRESYNC) begin
              if (!match) begin
                s_nxt.dl = ACC_HUNT;
              end else if (s_r.good_cnt + 4'h1 >= s_r.conf_thr) begin
                s_nxt.dl = ACC_SYNC;
                s_nxt.bad_cnt = 4'h0;
                reach_sync = 1'b1;
              end else begin
                s_nxt.good_cnt = s_r.good_cnt + 4'h1;
              end
            end else begin
              htc_inc = 1'b1;
              if (match) begin
                s_nxt.bad_cnt = 4'h0;
                s_nxt.fwd = !is_idle;
                s_nxt.rx_out.hdr = win_nxt[39:8];
                s_nxt.rx_out.hdr_valid = !is_idle;
              end else if (s_r.bad_cnt + 4'h1 >= s_r.lost_thr) begin
                s_nxt.dl = ACC_HUNT;
                lost = 1'b1;
              end else begin
                s_nxt.bad_cnt = s_r.bad_cnt + 4'h1;
              end
            end
          end else if (s_r.rx_idx >= `ACC_PAY_FIRST) begin
            {s_nxt.rx_scr, pay} = scr8(s_r.rx_scr, line_rx_i.data, 1'b1);
            s_nxt.rx_out.data = pay;
            s_nxt.rx_out.valid = s_r.fwd;
          end
        end
        default: s_nxt.dl = ACC_HUNT;
      endcase
    end

    // Near-end anomalies and the loss defect, counted in line frames
    s_nxt.ever_sync = s_r.ever_sync | reach_sync;
    s_nxt.nncd = s_nxt.seen_data & !s_nxt.ever_sync;
    s_nxt.ocd_frame = s_r.ocd_frame | s_r.nocd;
    if (frame_i) begin
      hit = s_r.ocd_frame | s_r.nocd;
      s_nxt.ocd_frame = 1'b0;
      if (!hit || losw_i) begin
        s_nxt.lcd_cnt = 4'h0;
      end else if (!s_r.nlcd) begin
        s_nxt.lcd_cnt = s_r.lcd_cnt + 4'h1;
        s_nxt.nlcd = s_r.lcd_cnt + 4'h1 >= `ACC_LCD_FRAMES;
      end
    end
    if (reach_sync) begin
      s_nxt.nlcd = 1'b0;
      s_nxt.lcd_cnt = 4'h0;
    end
    // Set wins over the clears
    if (lost) begin
      s_nxt.nocd = 1'b1;
    end else if (reach_sync || (s_nxt.nlcd && !s_r.nlcd)) begin
      s_nxt.nocd = 1'b0;
    end

    // Failures need the condition to persist over frames
    cond = {s_r.nlcd, s_r.nncd};
    for (int k = 0; k < 2; k++) begin
      if (!cond[k]) begin
        s_nxt.pers[k] = 8'h0;
        s_nxt.fail[k] = 1'b0;
      end else if (frame_i && !s_r.fail[k]) begin
        s_nxt.pers[k] = s_r.pers[k] + 8'h1;
        s_nxt.fail[k] = s_r.pers[k] + 8'h1 >= s_r.persist;
      end
    end

    // Incoming maintenance messages
    if (eoc_rx_i.valid) begin
      if (eoc_rx_i.sop) begin
        s_nxt.eoc_idx = 3'h1;
        s_nxt.eoc_id = eoc_rx_i.data;
        req = eoc_rx_i.data == `ACC_MSG_REQ;
      end else if (s_r.eoc_idx != 3'h0) begin
        s_nxt.eoc_idx = s_r.eoc_idx + 3'h1;
        unique case (s_r.eoc_idx)
          3'h1: s_nxt.eoc_b2 = eoc_rx_i.data;
          3'h2: s_nxt.eoc_hi = eoc_rx_i.data;
          3'h3: begin
            s_nxt.eoc_idx = 3'h0;
            if (s_r.eoc_id == `ACC_MSG_STAT) begin
              s_nxt.fncd = s_r.eoc_b2[7];
              s_nxt.focd = s_r.eoc_b2[6] & !s_r.eoc_b2[7];
              s_nxt.flcd = s_r.eoc_b2[5];
              s_nxt.fhec = {s_r.eoc_hi, eoc_rx_i.data} != 16'h0;
            end
          end
          default: s_nxt.eoc_idx = 3'h0;
        endcase
      end
    end

    // Report scheduling: replies and once-a-second autonomous repeats
    fail_any = |s_r.fail;
    s_nxt.fail_q = fail_any;
    if (!fail_any) begin
      s_nxt.acked = 1'b0;
    end else if (req) begin
      s_nxt.acked = 1'b1;
    end
    auto_send = fail_any & !s_r.acked
                & ((fail_any & !s_r.fail_q) | (s_r.timer == 28'h0));
    if (auto_send) begin
      s_nxt.timer = PERIOD_LAST;
    end else if (s_r.timer != 28'h0) begin
      s_nxt.timer = s_r.timer - 28'h1;
    end
    // Only one indicator may be set; no-delineation outranks loss
    oct2[7] = s_r.nncd;
    oct2[5] = !s_r.nncd & (s_r.lcd_stk | s_r.nlcd);
    oct2[6] = !s_r.nncd & !oct2[5] & (s_r.ocd_stk | s_r.nocd);
    oct2[4:2] = 3'b000;
    oct2[1] = s_r.fail[0];
    oct2[0] = s_r.fail[1];
    if (s_r.eoc_o.valid && eoc_tx_ready_i) begin
      s_nxt.msg = {s_r.msg[23:0], 8'h00};
      s_nxt.msg_left = s_r.msg_left - 3'h1;
    end
    if ((req || auto_send || s_r.pend) && s_r.msg_left == 3'h0) begin
      snap = 1'b1;
      s_nxt.msg = {`ACC_MSG_STAT, oct2, s_r.hvc};
      s_nxt.msg_left = `ACC_MSG_LEN;
      s_nxt.pend = 1'b0;
    end else if (req || auto_send) begin
      s_nxt.pend = 1'b1;
    end
    s_nxt.eoc_o.valid = s_nxt.msg_left != 3'h0;
    s_nxt.eoc_o.sop = s_nxt.msg_left == `ACC_MSG_LEN;
    s_nxt.eoc_o.data = s_nxt.msg[31:24];

    // Since-report stickies and counters; a new event beats the clear
    s_nxt.ocd_stk = (s_r.ocd_stk & !snap) | s_r.nocd;
    s_nxt.lcd_stk = (s_r.lcd_stk & !snap) | s_r.nlcd;
    s_nxt.hvc = (snap ? 16'h0 : s_r.hvc) + {15'h0, nhec};
    s_nxt.htc = (snap ? 32'h0 : s_r.htc) + {31'h0, htc_inc};

    // Register port
    s_nxt.hvc_tot = ((bus_i.wr && bus_i.addr == `ACC_A_HVC_TOT) ? 32'h0
                     : s_r.hvc_tot) + {31'h0, nhec};
    s_nxt.htc_tot = ((bus_i.wr && bus_i.addr == `ACC_A_HTC_TOT) ? 32'h0
                     : s_r.htc_tot) + {31'h0, htc_inc};
    if (bus_i.wr && bus_i.addr == `ACC_A_CTRL) begin
      s_nxt.lost_thr = bus_i.wdata[`ACC_F_LOST];
      s_nxt.conf_thr = bus_i.wdata[`ACC_F_CONF];
      s_nxt.n_ch = bus_i.wdata[`ACC_F_NCH];
      s_nxt.z_ch = bus_i.wdata[`ACC_F_ZCH];
      s_nxt.persist = bus_i.wdata[`ACC_F_PERSIST];
    end
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        `ACC_A_CTRL: begin
          s_nxt.rdata[`ACC_F_LOST] = s_r.lost_thr;
          s_nxt.rdata[`ACC_F_CONF] = s_r.conf_thr;
          s_nxt.rdata[`ACC_F_NCH] = s_r.n_ch;
          s_nxt.rdata[`ACC_F_ZCH] = s_r.z_ch;
          s_nxt.rdata[`ACC_F_PERSIST] = s_r.persist;
        end
        `ACC_A_STATUS: s_nxt.rdata[12:0] = {s_r.acked, cfg_ok, s_r.flcd,
          s_r.fhec, s_r.focd, s_r.fncd, s_r.fail[1], s_r.fail[0],
          s_r.nlcd, s_r.nocd, s_r.nncd, s_r.dl};
        `ACC_A_HVC: s_nxt.rdata[15:0] = s_r.hvc;
        `ACC_A_HTC: s_nxt.rdata = s_r.htc;
        `ACC_A_HVC_TOT: s_nxt.rdata = s_r.hvc_tot;
        `ACC_A_HTC_TOT: s_nxt.rdata = s_r.htc_tot;
        default: s_nxt.rdata = 32'h0;
      endcase
    end

    // Synchronous reset: constants only
    if (rst_i) begin
      s_nxt = '0;
      s_nxt.lost_thr = `ACC_LOST_DEF;
      s_nxt.conf_thr = `ACC_CONF_DEF;
      s_nxt.n_ch = `ACC_N_DEF;
      s_nxt.persist = `ACC_PERSIST_DEF;
      s_nxt.fncd = 1'b1;
    end
  end

  // State register
  always_ff @(posedge clock_i) begin
    s_r <= s_nxt;
  end

  // Checks on the delineation, transmit header check and reporting behaviour
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  sequence hdr_check;
    line_rx_i.valid && s_r.rx_idx == `ACC_HEC_IDX && s_r.dl != ACC_HUNT;
  endsequence
  sequence hdr_bad;
    hdr_check and !match;
  endsequence

  a_hunt_first_match: assert property (
    line_rx_i.valid && s_r.dl == ACC_HUNT && match
    |=> s_r.dl == ACC_PRESYNC && s_r.rx_idx == `ACC_PAY_FIRST)
    else $error("hunt match did not enter presync");
  a_presync_miss_hunts: assert property (
    hdr_bad ##0 s_r.dl == ACC_PRESYNC |=> s_r.dl == ACC_HUNT)
    else $error("presync miss did not return to hunt");
  a_sync_lost_count: assert property (
    hdr_bad ##0 s_r.dl == ACC_SYNC ##0 s_r.bad_cnt + 4'h1 >= s_r.lost_thr
    |=> s_r.dl == ACC_HUNT ##1 s_r.nocd)
    else $error("sync loss not taken at threshold");
  a_hdr_err_counted: assert property (
    hdr_bad and s_r.msg_left != 3'h0
    |=> s_r.hvc == $past(s_r.hvc) + 16'h1)
    else $error("header error not counted");
  a_fwd_no_idle: assert property (
    rx_cell_o.hdr_valid |-> rx_cell_o.hdr != IDLE_HDR
    && $past(s_r.dl) == ACC_SYNC)
    else $error("idle or unsynced header forwarded");
  a_tx_hec_byte: assert property (
    line_tx_req_i && s_r.tx_idx == `ACC_HEC_IDX
    |=> line_tx_o.valid && line_tx_o.data == (s_r.tx_crc ^ `ACC_HEC_COSET))
    else $error("sent header check byte is wrong");
  a_nncd_after_sync: assert property (
    s_r.ever_sync |-> !s_r.nncd)
    else $error("no-delineation held after first sync");
  a_request_replied: assert property (
    eoc_rx_i.valid && eoc_rx_i.sop && eoc_rx_i.data == `ACC_MSG_REQ
    && s_r.msg_left == 3'h0
    |=> eoc_tx_o.valid && eoc_tx_o.sop
    && eoc_tx_o.data == `ACC_MSG_STAT)
    else $error("status request not answered");
  a_report_one_ind: assert property (
    eoc_tx_o.valid && s_r.msg_left == 3'h3
    |-> $countones(eoc_tx_o.data[7:5]) <= 1)
    else $error("more than one indicator set");
endmodule
`default_nettype wire

// ---- acc_far_model.sv ----
/*
  Far side of the convergence block: a line transceiver that asks for a
  byte every third cycle, loops the line back, marks frames, and takes
  maintenance bytes promptly or slowly.
  Assumes one clock shared with the block and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module acc_far_model
  import acc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire acc_lbyte_t line_tx_i,
  input wire logic corrupt_i,
  input wire logic slow_i,
  output var logic line_tx_req_o,
  output var acc_lbyte_t line_rx_o,
  output var logic frame_o,
  output logic losw_o,
  output var logic eoc_ready_o
);
  logic [1:0] gap_r;
  logic [7:0] frm_r;
  // Requests three cycles apart so the source can advance; 256-cycle frames
  always_ff @(posedge clock_i) begin
    gap_r <= (rst_i || gap_r == 2'd2) ? 2'd0 : gap_r + 2'd1;
    frm_r <= rst_i ? 8'h00 : frm_r + 8'h01;
    line_tx_req_o <= !rst_i && gap_r == 2'd2;
    frame_o <= !rst_i && frm_r == 8'hff;
    eoc_ready_o <= !slow_i || frm_r[0];
  end
  // Whole bytes loop back in order; between bytes the data does not hold
  always_ff @(posedge clock_i) begin
    line_rx_o.valid <= !rst_i && line_tx_i.valid;
    if (rst_i)
      line_rx_o.data <= 8'h00;
    else if (line_tx_i.valid)
      line_rx_o.data <= line_tx_i.data ^ (corrupt_i ? 8'hff : 8'h00);
    else
      line_rx_o.data <= ~line_rx_o.data;
  end
  // Frame sync word never lost here
  assign losw_o = 1'b0;
endmodule
`default_nettype wire

// ---- tb_top.sv ----
/*
  Self-checking bench of the cell convergence block with the line partner.
  Assumes the block's package and constants file are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import acc_pkg::*;
;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  acc_bus_t bus_i = '0;
  acc_byte_t tx_cell_i = '0;
  acc_byte_t eoc_rx_i = '0;
  logic corrupt = 1'b0;
  logic slow = 1'b0;
  logic [31:0] bus_rdata_o;
  logic tx_ack_o, line_tx_req_i, frame_i, losw_i, eoc_tx_ready_i;
  acc_lbyte_t line_tx_o, line_rx_i;
  acc_cell_out_t rx_cell_o;
  acc_byte_t eoc_tx_o;
  int bad_count = 0;
  int tests_run = 0;
  logic [8:0] tx_q[$];
  logic [31:0] exp_q[$];
  logic [7:0] eoc_q[$];
  logic [19:0] far_tab[5] = '{20'h00000, 20'h40002, 20'h20008,
                              20'h00054, 20'h80001};

  always #2.5 clock_i = ~clock_i;

  acc_convergence #(.REPORT_CYC(50)) dut (.clock_i(clock_i), .rst_i(rst_i),
    .bus_i(bus_i), .bus_rdata_o(bus_rdata_o), .tx_cell_i(tx_cell_i),
    .tx_ack_o(tx_ack_o), .line_tx_req_i(line_tx_req_i),
    .line_tx_o(line_tx_o), .line_rx_i(line_rx_i), .rx_cell_o(rx_cell_o),
    .frame_i(frame_i), .losw_i(losw_i), .eoc_rx_i(eoc_rx_i),
    .eoc_tx_o(eoc_tx_o), .eoc_tx_ready_i(eoc_tx_ready_i));

  acc_far_model far (.clock_i(clock_i), .rst_i(rst_i), .line_tx_i(line_tx_o),
    .corrupt_i(corrupt), .slow_i(slow), .line_tx_req_o(line_tx_req_i),
    .line_rx_o(line_rx_i), .frame_o(frame_i), .losw_o(losw_i),
    .eoc_ready_o(eoc_tx_ready_i));

  // Header check byte as the far receiver would compute it
  function automatic logic [7:0] hec_of(input logic [31:0] h);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 31; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
    return c ^ 8'h55;
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Each access ends one edge after its strobe so no step drives bus_i twice
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus_i <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
    @(posedge clock_i);
    bus_i <= '0;
    @(posedge clock_i);
  endtask

  // Read data stands only in the cycle after the strobe; taken at its end
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    bus_i <= '{addr:a, wdata:32'h0, wr:1'b0, rd:1'b1};
    @(posedge clock_i);
    bus_i <= '0;
    @(posedge clock_i);
    d = bus_rdata_o;
  endtask

  task automatic wait_state(input logic [1:0] s);
    logic [31:0] v;
    int n;
    n = 0;
    do begin
      rd(8'h04, v);
      n++;
    end while (v[1:0] !== s && n < 6000);
    check("dlin_state", {30'h0, v[1:0]}, {30'h0, s});
  endtask

  task automatic eoc_send(input logic [31:0] m, input int len);
    for (int i = 0; i < len; i++) begin
      @(posedge clock_i);
      eoc_rx_i <= '{data:m[31-8*i -: 8], valid:1'b1, sop:(i == 0)};
    end
    @(posedge clock_i);
    eoc_rx_i <= '0;
    repeat (4) @(posedge clock_i);
  endtask

  // Random non-idle user cell; a set header bit keeps it apart from idle
  task automatic send_cell();
    logic [31:0] h;
    logic [7:0] b;
    h = $urandom | 32'h0001_0000;
    for (int i = 0; i < 4; i++)
      tx_q.push_back({i == 0, h[31-8*i -: 8]});
    exp_q.push_back(h);
    repeat (48) begin
      b = 8'($urandom);
      tx_q.push_back({1'b0, b});
      exp_q.push_back({24'h0, b});
    end
  endtask

  // Cell source advances only on the consumption pulse
  always @(posedge clock_i) begin
    if (tx_ack_o === 1'b1 && tx_q.size() > 0)
      void'(tx_q.pop_front());
    tx_cell_i <= tx_q.size() > 0 ?
      '{data:tx_q[0][7:0], valid:1'b1, sop:tx_q[0][8]} : '0;
  end

  // Forwarded cells must be exactly the user cells, idle ones never
  always @(posedge clock_i) begin
    if (rx_cell_o.hdr_valid === 1'b1)
      check("rx_hdr", rx_cell_o.hdr, exp_q.size() ? exp_q.pop_front() : 'x);
    if (rx_cell_o.valid === 1'b1)
      check("rx_pay", {24'h0, rx_cell_o.data}, exp_q.size() ? exp_q.pop_front() : 'x);
    if (eoc_tx_o.valid === 1'b1 && eoc_tx_ready_i === 1'b1)
      eoc_q.push_back(eoc_tx_o.data);
  end

  // Hang guard, well beyond the expected run of about 6000 cycles
  initial begin
    #300000;
    bad_count++;
    end_of_test();
  end

  initial begin
    logic [31:0] v, hv;
    logic [7:0] lb[5];
    void'($urandom(32'h3519a198));
    repeat (2) @(posedge clock_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      do @(posedge clock_i); while (line_tx_o.valid !== 1'b1);
      lb[i] = line_tx_o.data;
    end
    for (int i = 0; i < 4; i++)
      check("idle_hdr", {24'h0, lb[i]}, (i == 3) ? 32'h1 : 32'h0);
    check("idle_hec", {24'h0, lb[4]}, {24'h0, hec_of(32'h1)});
    rd(8'h00, v);
    check("ctrl_reset", v, 32'h2800_0367);
    rd(8'h04, v);
    check("start_flags", {v[7], v[2], v[1:0] == 2'd2}, 32'h6);
    rd(8'h40, v);
    check("unmapped_rd", v, 32'h0);
    wait_state(2'd2);
    rd(8'h04, v);
    check("ncd_off", {31'h0, v[2]}, 32'h0);
    wr(8'h00, 32'h2800_0312);
    rd(8'h00, v);
    check("ctrl_wr", v, 32'h2800_0312);
    repeat (3) send_cell();
    for (int n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge clock_i);
    check("cells_left", exp_q.size(), 32'h0);
    rd(8'h0c, v);
    check("htc_cnt", v != 0, 32'h1);
    corrupt <= 1'b1;
    repeat (3500) @(posedge clock_i);
    rd(8'h04, v);
    check("loss_defect", {v[4], v[1:0] == 2'd2}, 32'h2);
    rd(8'h08, hv);
    check("hvc_cnt", hv != 0, 32'h1);
    rd(8'h10, v);
    check("hvc_total", v != 0, 32'h1);
    corrupt <= 1'b0;
    wait_state(2'd2);
    rd(8'h04, v);
    check("resync_flags", {v[4], v[3]}, 32'h0);
    rd(8'h08, hv);
    slow <= 1'b1;
    eoc_q.delete();
    eoc_send(32'h1100_0000, 1);
    for (int n = 0; n < 60 && eoc_q.size() < 4; n++) @(posedge clock_i);
    check("rep_len", eoc_q.size(), 32'h4);
    check("rep_id", {24'h0, eoc_q[0]}, 32'h91);
    check("rep_ind", {eoc_q[1][7], eoc_q[1][5]}, 32'h1);
    check("rep_hvc", {eoc_q[2], eoc_q[3]}, {16'h0, hv[15:0]});
    rd(8'h08, v);
    check("hvc_clear", v, 32'h0);
    foreach (far_tab[i]) begin
      eoc_send({8'h91, far_tab[i][19:12], 8'h00, far_tab[i][11:4]}, 4);
      rd(8'h04, v);
      check("far_flags", {28'h0, v[10:7]}, {28'h0, far_tab[i][3:0]});
    end
    end_of_test();
  end
endmodule
`default_nettype wire
